//--- hdl/ssx_defines.svh
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH

// ----------------------------------------
// instruction word layout
// ----------------------------------------
`define SSX_IW_W 16
`define SSX_PC_W 11
`define SSX_PC_RST 11'h000
`define SSX_ACCUMULATOR_RST 4'h0

// 9-bit prefixes, top of word, followed by 7-bit address
`define SSX_OP9_SKIP_BIT0 9'h110
`define SSX_OP9_SKIP_BIT1 9'h111
`define SSX_OP9_SKIP_BIT2 9'h114
`define SSX_OP9_SKIP_BIT3 9'h115
`define SSX_OP9_SUB_M 9'h034
`define SSX_OP9_SUBWB_M 9'h036
`define SSX_OP9_XOR_M 9'h070
`define SSX_OP9_XORWB_M 9'h072
// 7-bit prefixes sit under a clear top bit, so they are matched as 8 bits;
// matching only the top seven would alias the immediate xor onto the memory xor
`define SSX_OP8_SUB_I 8'h0E
`define SSX_OP8_XOR_I 8'h1C
`define SSX_OP8_XORWB_I 8'h1D
// 8-bit prefix for the write-back immediate subtract
`define SSX_OP8_SUBWB_I 8'h1F
`define SSX_OP_STOP 16'h0060

`define SSX_BIT3 2'h3
// bit index of the low skip forms is spread over opcode bits 2 and 0
`define SSX_SKIP_IDX_HI 2'h2
`define SSX_SKIP_IDX_LO 2'h0
`define SSX_PC_ONE 11'h001
`define SSX_PC_TWO 11'h002

`endif

//--- hdl/ssx_pkg.sv
package ssx_pkg;
`include "ssx_defines.svh"

   typedef enum logic [1:0]
   {
      SSX_RUN = 2'h1,
      SSX_STOPPED = 2'h2
   } ssx_mode_t;

   typedef struct packed
   {
      logic [6:0] addr;
      logic [3:0] wdata;
      logic we;
   } ssx_mem_t;

   typedef struct packed
   {
      logic [3:0] idx;
      logic [3:0] wdata;
      logic we;
   } ssx_wr_t;

   typedef struct packed
   {
      ssx_mode_t mode;
      logic [10:0] pc;
      logic [3:0] accumulator;
      logic carry_flag;
      logic zero_flag;
      ssx_mem_t mem;
      ssx_wr_t wr;
      logic osc_stop;
   } ssx_state_t;
endpackage

//--- hdl/ssx_core.sv
`timescale 1ns/1ps
`include "ssx_defines.svh"

// Overview of operation
// [RULE_01] bit-3 skip: memory bit 3 set advances program counter by two
// [RULE_02] bit-3 skip: memory bit 3 clear advances program counter by one
// [RULE_03] stop pattern halts oscillator and enters stop state
// [RULE_04] stopped core wakes on falling edge of interrupt port, runs next
// [RULE_05] memory minus accumulator into accumulator only, carry and zero updated
// [RULE_06] memory minus accumulator into accumulator and memory, flags updated
// [RULE_07] working register minus immediate into accumulator only, flags updated
// [RULE_08] working register minus immediate into accumulator and register
// [RULE_09] memory xor accumulator into accumulator, zero only updated
// [RULE_10] memory xor accumulator into memory and accumulator, zero only
// [RULE_11] working register xor immediate into accumulator, zero only
// [RULE_12] working register xor immediate into register and accumulator
// [RULE_13] bit 0..2 skips behave like bit-3 skip
// [RULE_14] zero flag set when accumulator result is zero
// [RULE_15] every instruction takes one cycle, then program counter advances
module ssx_core
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic [3:0] mem_rdata,
   input wire logic [3:0] wr_rdata,
   input wire logic external_interrupt_input_port,
   output logic [6:0] mem_addr,
   output logic [3:0] mem_wdata,
   output logic mem_we,
   output logic [3:0] wr_idx,
   output logic [3:0] wr_wdata,
   output logic wr_we,
   output logic [10:0] pc,
   output logic [3:0] accumulator,
   output logic carry_flag,
   output logic zero_flag,
   output logic osc_stop
);
   import ssx_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // carry means borrow free: set when a >= b
   function automatic logic [4:0] ssx_sub(input logic [3:0] a, input logic [3:0] b);
      logic [4:0] d;
      d = {1'b0, a} - {1'b0, b};
      ssx_sub = {~d[4], d[3:0]};
   endfunction

   ssx_state_t s_q;
   ssx_state_t s_d;
   logic port_q;
   logic fall;
   logic [8:0] op9;
   logic [7:0] op8;
   logic [4:0] sr;
   logic [3:0] res;
   logic res_en;
   logic carry_en;
   logic [3:0] imm;

   assign op9 = instr[15:7];
   assign op8 = instr[15:8];
   assign imm = instr[7:4];
   // the port is taken as synchronous; only the previous level is kept
   assign fall = port_q & ~external_interrupt_input_port;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.mem.we = 1'b0;
      s_d.wr.we = 1'b0;
      res = 4'h0;
      res_en = 1'b0;
      carry_en = 1'b0;
      sr = 5'h00;
      case (s_q.mode)
         SSX_STOPPED:
         begin
            if (fall)
            begin
               s_d.mode = SSX_RUN; // RULE_04
               s_d.osc_stop = 1'b0; // RULE_04
            end
         end
         SSX_RUN:
         begin
            if (instr_valid)
            begin
               s_d.pc = s_q.pc + `SSX_PC_ONE; // RULE_15 RULE_02
               s_d.mem.addr = instr[6:0];
               s_d.wr.idx = instr[3:0];
               if (instr == `SSX_OP_STOP)
               begin
                  s_d.mode = SSX_STOPPED; // RULE_03
                  s_d.osc_stop = 1'b1; // RULE_03
               end
               else if (op9 == `SSX_OP9_SKIP_BIT3)
               begin
                  if (mem_rdata[`SSX_BIT3])
                     s_d.pc = s_q.pc + `SSX_PC_TWO; // RULE_01
               end
               else if (op9 == `SSX_OP9_SKIP_BIT0 || op9 == `SSX_OP9_SKIP_BIT1
                  || op9 == `SSX_OP9_SKIP_BIT2)
               begin
                  if (mem_rdata[{op9[`SSX_SKIP_IDX_HI], op9[`SSX_SKIP_IDX_LO]}])
                     s_d.pc = s_q.pc + `SSX_PC_TWO; // RULE_13
               end
               else if (op9 == `SSX_OP9_SUB_M || op9 == `SSX_OP9_SUBWB_M)
               begin
                  sr = ssx_sub(mem_rdata, s_q.accumulator); // RULE_05
                  res = sr[3:0];
                  res_en = 1'b1;
                  carry_en = 1'b1;
                  s_d.mem.we = (op9 == `SSX_OP9_SUBWB_M); // RULE_06
               end
               else if (op9 == `SSX_OP9_XOR_M || op9 == `SSX_OP9_XORWB_M)
               begin
                  res = mem_rdata ^ s_q.accumulator; // RULE_09
                  res_en = 1'b1;
                  s_d.mem.we = (op9 == `SSX_OP9_XORWB_M); // RULE_10
               end
               else if (op8 == `SSX_OP8_SUBWB_I)
               begin
                  sr = ssx_sub(wr_rdata, imm);
                  res = sr[3:0];
                  res_en = 1'b1;
                  carry_en = 1'b1;
                  s_d.wr.we = 1'b1; // RULE_08
               end
               else if (op8 == `SSX_OP8_SUB_I)
               begin
                  sr = ssx_sub(wr_rdata, imm); // RULE_07
                  res = sr[3:0];
                  res_en = 1'b1;
                  carry_en = 1'b1;
               end
               else if (op8 == `SSX_OP8_XOR_I || op8 == `SSX_OP8_XORWB_I)
               begin
                  res = wr_rdata ^ imm; // RULE_11
                  res_en = 1'b1;
                  s_d.wr.we = (op8 == `SSX_OP8_XORWB_I); // RULE_12
               end
               if (res_en)
               begin
                  s_d.accumulator = res;
                  s_d.mem.wdata = res;
                  s_d.wr.wdata = res;
                  s_d.zero_flag = (res == 4'h0); // RULE_14
               end
               if (carry_en)
                  s_d.carry_flag = sr[4];
            end
         end
         default:
         begin
            s_d.mode = SSX_RUN;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.mode <= SSX_RUN;
         s_q.pc <= `SSX_PC_RST;
         s_q.accumulator <= `SSX_ACCUMULATOR_RST;
         port_q <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
         port_q <= external_interrupt_input_port;
      end
   end

   assign mem_addr = s_q.mem.addr;
   assign mem_wdata = s_q.mem.wdata;
   assign mem_we = s_q.mem.we;
   assign wr_idx = s_q.wr.idx;
   assign wr_wdata = s_q.wr.wdata;
   assign wr_we = s_q.wr.we;
   assign pc = s_q.pc;
   assign accumulator = s_q.accumulator;
   assign carry_flag = s_q.carry_flag;
   assign zero_flag = s_q.zero_flag;
   assign osc_stop = s_q.osc_stop;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_SKIP3_SET: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
      (s_q.mode == SSX_RUN && instr_valid && op9 == `SSX_OP9_SKIP_BIT3 && mem_rdata[3])
      |=> pc == $past(pc) + `SSX_PC_TWO)
      else $error("bit3 skip did not add two");
   AST_SKIP3_CLR: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
      (s_q.mode == SSX_RUN && instr_valid && op9 == `SSX_OP9_SKIP_BIT3 && !mem_rdata[3])
      |=> pc == $past(pc) + `SSX_PC_ONE)
      else $error("bit3 no-skip did not add one");
   AST_STOP_ENTER: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
      (s_q.mode == SSX_RUN && instr_valid && instr == `SSX_OP_STOP) |=> osc_stop)
      else $error("stop did not halt oscillator");
   AST_STOP_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
      (osc_stop && !fall) |=> osc_stop && $stable(pc))
      else $error("stopped core moved without wake edge");
   AST_WAKE: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
      (osc_stop && fall) |=> !osc_stop)
      else $error("falling edge did not wake core");
   AST_SUB_MEM: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
      (s_q.mode == SSX_RUN && instr_valid && op9 == `SSX_OP9_SUB_M)
      |=> accumulator == $past(mem_rdata) - $past(accumulator) && !mem_we
      && carry_flag == ($past(mem_rdata) >= $past(accumulator)))
      else $error("memory subtract wrong");
   AST_SUBWB_MEM: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
      (s_q.mode == SSX_RUN && instr_valid && op9 == `SSX_OP9_SUBWB_M)
      |=> mem_we && mem_wdata == accumulator && mem_addr == $past(instr[6:0]))
      else $error("memory subtract write-back wrong");
   AST_SUB_IMM: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
      (s_q.mode == SSX_RUN && instr_valid && op8 == `SSX_OP8_SUB_I)
      |=> accumulator == $past(wr_rdata) - $past(imm) && !wr_we)
      else $error("immediate subtract wrong");
   AST_SUBWB_IMM: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
      (s_q.mode == SSX_RUN && instr_valid && op8 == `SSX_OP8_SUBWB_I)
      |=> wr_we && wr_wdata == accumulator && wr_idx == $past(instr[3:0]))
      else $error("immediate subtract write-back wrong");
   AST_XOR_CF: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
      (s_q.mode == SSX_RUN && instr_valid && (op9 == `SSX_OP9_XOR_M
      || op9 == `SSX_OP9_XORWB_M)) |=> $stable(carry_flag)
      && accumulator == ($past(mem_rdata) ^ $past(accumulator)))
      else $error("memory xor wrong");
   AST_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
      (s_q.mode == SSX_RUN && instr_valid && res_en) |=> zero_flag == (accumulator == 4'h0))
      else $error("zero flag mismatch");
endmodule

//--- tb/skip_sub_xor_stop_exec_bench.sv
`timescale 1ns/1ps

module skip_sub_xor_stop_exec_bench;
   import ssx_pkg::*;

   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic instr_valid = 1'b0;
   logic [3:0] mem_rdata = 4'h0;
   logic [3:0] wr_rdata = 4'h0;
   logic wake_port = 1'b1;
   logic [6:0] mem_addr;
   logic [3:0] mem_wdata;
   logic mem_we;
   logic [3:0] wr_idx;
   logic [3:0] wr_wdata;
   logic wr_we;
   logic [10:0] pc;
   logic [3:0] accumulator;
   logic carry_flag;
   logic zero_flag;
   logic osc_stop;
   int n_errors = 0;
   int compares = 0;
   logic [10:0] exp_pc = 11'h000;
   logic exp_carry = 1'b0;

   always #5 clock = ~clock;

   ssx_core dut
   (
      .clock(clock),
      .rst_n(rst_n),
      .instr(instr),
      .instr_valid(instr_valid),
      .mem_rdata(mem_rdata),
      .wr_rdata(wr_rdata),
      .external_interrupt_input_port(wake_port),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_we(mem_we),
      .wr_idx(wr_idx),
      .wr_wdata(wr_wdata),
      .wr_we(wr_we),
      .pc(pc),
      .accumulator(accumulator),
      .carry_flag(carry_flag),
      .zero_flag(zero_flag),
      .osc_stop(osc_stop)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // memory read is combinational, so data goes out with the word
   task run(input logic [15:0] i, input logic [3:0] m, input logic [3:0] w);
      @(posedge clock);
      instr <= i;
      mem_rdata <= m;
      wr_rdata <= w;
      instr_valid <= 1'b1;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
   endtask

   // working register 0 reads zero, so xor with the immediate loads it
   task load_accumulator(input logic [3:0] v);
      run({1'b0, 7'h1C, v, 4'h0}, 4'h0, 4'h0);
      exp_pc++;
      chk("accumulator", 16'(v), 16'(accumulator));
      chk("zero_flag", 16'(v == 4'h0), 16'(zero_flag));
   endtask

   task results;
      $display("compares %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task skip_test;
      logic [8:0] ops [4] = '{9'h110, 9'h111, 9'h114, 9'h115};
      logic [3:0] m;
      for (int j = 0; j < 4; j++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            // clear case sets all other bits to catch a wrong bit index
            m = s ? (4'h1 << j) : ~(4'h1 << j);
            run({ops[j], 7'h2B}, m, 4'h0);
            exp_pc = exp_pc + (s ? 11'h002 : 11'h001);
            chk("pc", 16'(exp_pc), 16'(pc));
         end
      end
      $display("skip test done");
   endtask

   task alu_test;
      logic [3:0] xs [5] = '{4'h5, 4'h3, 4'h7, 4'h0, 4'hF};
      logic [3:0] ys [5] = '{4'h3, 4'h5, 4'h7, 4'hF, 4'h0};
      logic [15:0] i;
      logic [6:0] a;
      logic [3:0] r;
      logic wb;
      logic imm;
      for (int k = 0; k < 8; k++)
      begin
         for (int n = 0; n < 5; n++)
         begin
            imm = k[1];
            wb = k[0];
            a = {k[2:0], xs[n]};
            if (!imm)
               load_accumulator(ys[n]);
            case (k)
               0: i = {9'h034, a};
               1: i = {9'h036, a};
               2: i = {1'b0, 7'h0E, ys[n], 4'h6};
               3: i = {8'h1F, ys[n], 4'h6};
               4: i = {9'h070, a};
               5: i = {9'h072, a};
               6: i = {1'b0, 7'h1C, ys[n], 4'h6};
               default: i = {1'b0, 7'h1D, ys[n], 4'h6};
            endcase
            r = (k < 4) ? xs[n] - ys[n] : xs[n] ^ ys[n];
            // xor forms must leave carry where the previous op put it
            if (k < 4)
               exp_carry = (xs[n] >= ys[n]);
            run(i, xs[n], xs[n]);
            exp_pc++;
            chk("accumulator", 16'(r), 16'(accumulator));
            chk("carry_flag", 16'(exp_carry), 16'(carry_flag));
            chk("zero_flag", 16'(r == 4'h0), 16'(zero_flag));
            chk("pc", 16'(exp_pc), 16'(pc));
            chk("mem_we", 16'(wb && !imm), 16'(mem_we));
            chk("wr_we", 16'(wb && imm), 16'(wr_we));
            if (wb && !imm)
            begin
               chk("mem_addr", 16'(a), 16'(mem_addr));
               chk("mem_wdata", 16'(r), 16'(mem_wdata));
            end
            if (wb && imm)
            begin
               chk("wr_idx", 16'h0006, 16'(wr_idx));
               chk("wr_wdata", 16'(r), 16'(wr_wdata));
            end
         end
      end
      $display("alu test done");
   endtask

   task stop_test;
      load_accumulator(4'h2);
      run(16'h0060, 4'h0, 4'h0);
      exp_pc++;
      chk("osc_stop", 16'h0001, 16'(osc_stop));
      // a word offered while halted must be dropped
      run({1'b0, 7'h1C, 4'h9, 4'h0}, 4'h0, 4'h0);
      chk("accumulator", 16'h0002, 16'(accumulator));
      chk("pc", 16'(exp_pc), 16'(pc));
      chk("osc_stop", 16'h0001, 16'(osc_stop));
      @(posedge clock);
      wake_port <= 1'b0;
      @(posedge clock);
      #1;
      chk("osc_stop", 16'h0000, 16'(osc_stop));
      load_accumulator(4'hC);
      chk("pc", 16'(exp_pc), 16'(pc));
      @(posedge clock);
      wake_port <= 1'b1;
      $display("stop test done");
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk("pc", 16'h0000, 16'(pc));
      chk("osc_stop", 16'h0000, 16'(osc_stop));
      skip_test;
      alu_test;
      stop_test;
      results;
   end

   initial
   begin
      #20000;
      n_errors++;
      $display("unexpected watchdog: expected finish, seen hang");
      results;
   end
endmodule
